// [rtl/float_add_coef_pkg.sv]
// How it works
// - double precision, no special case, go present: raise sample lower half and center.
// - no special case and go present: raise sample exponent for the fourth period.
// - period two picks larger-exponent coefficient as reference, registered for period three.
// - sign of difference one means operand j larger; steers reference and shift operand.
// - pick shift or reference round bit per role, placed just below coefficient bit 0.
// - reference widened to 96 bits: coefficient 48-95, round 47, sign fills 0-46.
// - shifted operand sits at 47-95, right-shifted by difference, sign fills elsewhere.
// - low shift controls re-complemented when sign of difference is one.
// - ranks one, two, three shift right by four, two, one under their controls.
// - first three ranks give shifts zero to seven, covering bits 40 through 95.
// - ranks one and two in period two, registered; rank three onward in period three.
// - translator decodes 8 and 16 controls to one-hot 0/8/16/24 for rank four.
// - second group 0/32/64/96 gated with 128 drives rank five; 128 also direct.
// - adder bit 96 carries reference sign and shifted sign for overflow room.
// - end-around borrow always for two positives, never for two negatives.
// - operands complemented entering stage one, which forms enables and borrows.
// - ten nine-bit sections plus one seven-bit; two three-bit groups per section bottom.
// - partial sum registered for period four; stage two forms ones-complement sum.
// - carry into the 96th bit (bit 95) raises coefficient overflow and a one-bit right shift.
// - overflow only with alike signs, decided by borrow to bit 95 from stage one.
// - single precision outputs upper 48 bits, double lower 48, shifted on overflow.
// - single precision sends bits 48-95, or 49-96 on overflow, to destination 0-47.
// - single precision, no special case, go present: raise sample upper half and center.
package float_add_coef_pkg;

    // ==================================================================
    // datapath geometry
    localparam int COEF_W = 48;
    localparam int WIDE_W = 96;
    localparam int SUM_W = 97;
    localparam int SEC_W = 9;
    localparam int N_SEC = 11;
    localparam int GRP_W = 3;
    localparam int N_GRP = 22;

    // ==================================================================
    // register offsets (byte addresses)
    localparam logic [7:0] ADDR_OPJ_LO = 8'h00;
    localparam logic [7:0] ADDR_OPJ_HI = 8'h04;
    localparam logic [7:0] ADDR_OPK_LO = 8'h08;
    localparam logic [7:0] ADDR_OPK_HI = 8'h0C;
    localparam logic [7:0] ADDR_SHIFT = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h14;
    localparam logic [7:0] ADDR_GO = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_RES_LO = 8'h20;
    localparam logic [7:0] ADDR_RES_HI = 8'h24;

    // ==================================================================
    // field positions
    localparam int SHIFT_SOD_BIT = 8;
    localparam int CTRL_DP_BIT = 0;
    localparam int CTRL_SPC_BIT = 1;
    localparam int CTRL_RND_SHJ_BIT = 2;
    localparam int CTRL_RND_SHK_BIT = 3;
    localparam int CTRL_RND_REFJ_BIT = 4;
    localparam int CTRL_RND_REFK_BIT = 5;
    localparam int GO_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_OVF_BIT = 1;
    localparam int STAT_EXP_BIT = 2;

    // ==================================================================
    // reset values and bus answers
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [47:0] RST_COEF = 48'h0000_0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : float_add_coef_pkg

// [rtl/float_add_coefficient_path.sv]
`timescale 1ns/1ps
module float_add_coefficient_path import float_add_coef_pkg::*; (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [7:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    output logic [47:0] coef_result_out,
    output logic coef_overflow_out,
    output logic sample_exponent_out,
    output logic result_valid_out
);

    // ==================================================================
    // bus slave: write channels
    logic aw_got_q;
    logic w_got_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic aw_fire;
    logic w_fire;
    logic wr_now;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic [31:0] wr_old;
    logic [31:0] wr_merged;

    // operand and control registers
    logic [31:0] opj_lo_q;
    logic [15:0] opj_hi_q;
    logic [31:0] opk_lo_q;
    logic [15:0] opk_hi_q;
    logic [8:0] shift_q;
    logic [5:0] ctrl_q;
    logic go_p1;

    // address and data may arrive in either order; hold the early one
    assign awready_out = !aw_got_q && !bvalid_q;
    assign wready_out = !w_got_q && !bvalid_q;
    assign aw_fire = awvalid_in && awready_out;
    assign w_fire = wvalid_in && wready_out;
    assign wr_now = (aw_got_q || aw_fire) && (w_got_q || w_fire);
    assign wr_addr = aw_got_q ? aw_addr_q : awaddr_in;
    assign wr_data = w_got_q ? w_data_q : wdata_in;
    assign wr_strb = w_got_q ? w_strb_q : wstrb_in;
    assign bvalid_out = bvalid_q;
    assign bresp_out = bresp_q;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= RST_WORD;
            w_strb_q <= '0;
        end else if (wr_now) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
        end else begin
            if (aw_fire) begin
                aw_got_q <= 1'b1;
                aw_addr_q <= awaddr_in;
            end
            if (w_fire) begin
                w_got_q <= 1'b1;
                w_data_q <= wdata_in;
                w_strb_q <= wstrb_in;
            end
        end
    end

    // response follows both halves; unmapped or misaligned answers slverr
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_now) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && bready_in) begin
            bvalid_q <= 1'b0;
        end
    end

    // old value of the addressed word, merged with the strobed bytes
    always_comb begin
        wr_hit = (wr_addr[1:0] == 2'h0) && (wr_addr <= ADDR_RES_HI);
        case (wr_addr)
            ADDR_OPJ_LO: wr_old = opj_lo_q;
            ADDR_OPJ_HI: wr_old = {16'h0000, opj_hi_q};
            ADDR_OPK_LO: wr_old = opk_lo_q;
            ADDR_OPK_HI: wr_old = {16'h0000, opk_hi_q};
            ADDR_SHIFT: wr_old = {23'h00_0000, shift_q};
            ADDR_CTRL: wr_old = {26'h000_0000, ctrl_q};
            default: wr_old = RST_WORD;
        endcase
        for (int i = 0; i < 4; i++) begin
            wr_merged[i*8 +: 8] = wr_strb[i] ? wr_data[i*8 +: 8] : wr_old[i*8 +: 8];
        end
    end

    // software-owned registers; status and results are read-only
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            opj_lo_q <= RST_WORD;
            opj_hi_q <= '0;
            opk_lo_q <= RST_WORD;
            opk_hi_q <= '0;
            shift_q <= '0;
            ctrl_q <= '0;
        end else if (wr_now) begin
            case (wr_addr)
                ADDR_OPJ_LO: opj_lo_q <= wr_merged;
                ADDR_OPJ_HI: opj_hi_q <= wr_merged[15:0];
                ADDR_OPK_LO: opk_lo_q <= wr_merged;
                ADDR_OPK_HI: opk_hi_q <= wr_merged[15:0];
                ADDR_SHIFT: shift_q <= wr_merged[8:0];
                ADDR_CTRL: ctrl_q <= wr_merged[5:0];
                default: ;
            endcase
        end
    end

    // a go write is the issue period; the pipe runs three more periods
    assign go_p1 = wr_now && (wr_addr == ADDR_GO) && wr_strb[0] && wr_data[GO_BIT];

    // ==================================================================
    // period two: operand selection and shift ranks one and two
    logic p2_q;
    logic p3_q;
    logic p4_q;
    logic sod;
    logic [47:0] coef_j;
    logic [47:0] coef_k;
    logic [47:0] ref_coef;
    logic [47:0] shf_coef;
    logic ref_rnd;
    logic shf_rnd;
    logic [2:0] sh_lo;
    logic [95:0] shf_wide;
    logic [95:0] rank1;
    logic [95:0] rank2;
    logic [95:0] ref_wide_q;
    logic [95:0] shf_q;
    logic ref_sign_q;
    logic shf_sign_q;
    logic sh1_q;
    logic [4:0] sh_hi_q;
    logic dp_q;
    logic spc_q;

    assign coef_j = {opj_hi_q, opj_lo_q};
    assign coef_k = {opk_hi_q, opk_lo_q};
    assign sod = shift_q[SHIFT_SOD_BIT];
    // larger exponent goes to reference, the other to rank one
    assign ref_coef = sod ? coef_j : coef_k;
    assign shf_coef = sod ? coef_k : coef_j;
    assign ref_rnd = sod ? ctrl_q[CTRL_RND_REFJ_BIT] : ctrl_q[CTRL_RND_REFK_BIT];
    assign shf_rnd = sod ? ctrl_q[CTRL_RND_SHK_BIT] : ctrl_q[CTRL_RND_SHJ_BIT];
    // the low controls come complemented when j is larger
    assign sh_lo = sod ? ~shift_q[2:0] : shift_q[2:0];
    // msb is the sign, so arithmetic shifts fill with shifted sign
    assign shf_wide = {shf_coef, shf_rnd, {47{shf_coef[47]}}};
    assign rank1 = sh_lo[2] ? 96'($signed(shf_wide) >>> 4) : shf_wide;
    assign rank2 = sh_lo[1] ? 96'($signed(rank1) >>> 2) : rank1;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            p2_q <= 1'b0;
            p3_q <= 1'b0;
            p4_q <= 1'b0;
        end else begin
            p2_q <= go_p1;
            p3_q <= p2_q;
            p4_q <= p3_q;
        end
    end

    // period-two results held for period three
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ref_wide_q <= '0;
            shf_q <= '0;
            ref_sign_q <= 1'b0;
            shf_sign_q <= 1'b0;
            sh1_q <= 1'b0;
            sh_hi_q <= '0;
            dp_q <= 1'b0;
            spc_q <= 1'b0;
        end else if (p2_q) begin
            ref_wide_q <= {ref_coef, ref_rnd, {47{ref_coef[47]}}};
            shf_q <= rank2;
            ref_sign_q <= ref_coef[47];
            shf_sign_q <= shf_coef[47];
            sh1_q <= sh_lo[0];
            sh_hi_q <= shift_q[7:3];
            dp_q <= ctrl_q[CTRL_DP_BIT];
            spc_q <= ctrl_q[CTRL_SPC_BIT];
        end
    end

    // ==================================================================
    // period three: ranks three to five and first adder stage
    logic [95:0] rank3;
    logic [55:0] rank3_win;
    logic [95:0] rank4;
    logic [95:0] rank5;
    logic [3:0] grp_a;
    logic [3:0] grp_b;
    logic [96:0] op_a;
    logic [96:0] op_b;
    logic [96:0] bit_en;
    logic [96:0] bit_br;
    logic [10:0] sec_en;
    logic [10:0] sec_br;
    logic [21:0] grp_en;
    logic [21:0] grp_br;

    assign rank3 = sh1_q ? 96'($signed(shf_q) >>> 1) : shf_q;
    // only bits 40-95 can hold data after at most seven places
    assign rank3_win = rank3[95:40];

    always_comb begin
        // one-hot translator, shift 0/8/16/24 and 0/32/64/96
        grp_a = 4'h1 << sh_hi_q[1:0];
        grp_b = (4'h1 << sh_hi_q[3:2]) & {4{!sh_hi_q[4]}};
        case (grp_a)
            4'h2: rank4 = 96'($signed({rank3_win, {40{rank3_win[55]}}}) >>> 8);
            4'h4: rank4 = 96'($signed({rank3_win, {40{rank3_win[55]}}}) >>> 16);
            4'h8: rank4 = 96'($signed({rank3_win, {40{rank3_win[55]}}}) >>> 24);
            default: rank4 = {rank3_win, {40{rank3_win[55]}}};
        endcase
        // shift 128 alone clears the operand to its sign
        if (sh_hi_q[4]) begin
            rank5 = {96{shf_sign_q}};
        end else begin
            case (grp_b)
                4'h2: rank5 = 96'($signed(rank4) >>> 32);
                4'h4: rank5 = 96'($signed(rank4) >>> 64);
                4'h8: rank5 = {96{shf_sign_q}};
                default: rank5 = rank4;
            endcase
        end
    end

    // bit 96 of each operand is its own sign
    assign op_a = {ref_sign_q, ref_wide_q};
    assign op_b = {shf_sign_q, rank5};
    // complemented entry: enable is a half sum, borrow a generate
    assign bit_en = (~op_a) ^ (~op_b);
    assign bit_br = (~op_a) & (~op_b);

    // section and group enables and borrows over the 9/9/../7 split
    always_comb begin
        for (int s = 0; s < N_SEC; s++) begin
            sec_en[s] = 1'b1;
            sec_br[s] = 1'b0;
            for (int i = 0; i < SEC_W; i++) begin
                if (s * SEC_W + i < SUM_W) begin
                    sec_br[s] = bit_br[s*SEC_W+i] | (bit_en[s*SEC_W+i] & sec_br[s]);
                    sec_en[s] = sec_en[s] & bit_en[s*SEC_W+i];
                end
            end
            for (int g = 0; g < 2; g++) begin
                grp_en[s*2+g] = 1'b1;
                grp_br[s*2+g] = 1'b0;
                for (int i = 0; i < GRP_W; i++) begin
                    grp_br[s*2+g] = bit_br[s*SEC_W+g*GRP_W+i]
                        | (bit_en[s*SEC_W+g*GRP_W+i] & grp_br[s*2+g]);
                    grp_en[s*2+g] = grp_en[s*2+g] & bit_en[s*SEC_W+g*GRP_W+i];
                end
            end
        end
    end

    // partial sum and sample controls held for period four
    logic [96:0] bit_en_q;
    logic [96:0] bit_br_q;
    logic [10:0] sec_en_q;
    logic [10:0] sec_br_q;
    logic [21:0] grp_en_q;
    logic [21:0] grp_br_q;
    logic ref_sign4_q;
    logic shf_sign4_q;
    logic samp_upper_q;
    logic samp_lower_q;
    logic samp_center_q;
    logic samp_exp_q;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            bit_en_q <= '0;
            bit_br_q <= '0;
            sec_en_q <= '0;
            sec_br_q <= '0;
            grp_en_q <= '0;
            grp_br_q <= '0;
            ref_sign4_q <= 1'b0;
            shf_sign4_q <= 1'b0;
        end else if (p3_q) begin
            bit_en_q <= bit_en;
            bit_br_q <= bit_br;
            sec_en_q <= sec_en;
            sec_br_q <= sec_br;
            grp_en_q <= grp_en;
            grp_br_q <= grp_br;
            ref_sign4_q <= ref_sign_q;
            shf_sign4_q <= shf_sign_q;
        end
    end

    // sample controls are live only for the period-four cycle
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            samp_upper_q <= 1'b0;
            samp_lower_q <= 1'b0;
            samp_center_q <= 1'b0;
            samp_exp_q <= 1'b0;
        end else begin
            samp_upper_q <= p3_q && !spc_q && !dp_q;
            samp_lower_q <= p3_q && !spc_q && dp_q;
            samp_center_q <= p3_q && !spc_q;
            samp_exp_q <= p3_q && !spc_q;
        end
    end

    // ==================================================================
    // period four: second adder stage, overflow and output selection
    logic eab;
    logic [10:0] sec_cin;
    logic [96:0] carry;
    logic [96:0] result;
    logic borrow96;
    logic coef_ovf;
    logic [47:0] upper_half;
    logic [47:0] lower_half;
    logic [47:0] coef_sel;

    always_comb begin
        // end-around borrow: carry-out of the top with no carry-in
        eab = 1'b0;
        for (int s = 0; s < N_SEC; s++) begin
            eab = sec_br_q[s] | (sec_en_q[s] & eab);
        end
        sec_cin[0] = eab;
        for (int s = 1; s < N_SEC; s++) begin
            sec_cin[s] = sec_br_q[s-1] | (sec_en_q[s-1] & sec_cin[s-1]);
        end
        for (int s = 0; s < N_SEC; s++) begin
            carry[s*SEC_W] = sec_cin[s];
            for (int i = 1; i < SEC_W; i++) begin
                if (s * SEC_W + i < SUM_W) begin
                    carry[s*SEC_W+i] = bit_br_q[s*SEC_W+i-1] | (bit_en_q[s*SEC_W+i-1] & carry[s*SEC_W+i-1]);
                end
            end
        end
    end

    // the complemented sum is turned back to true ones-complement form
    assign result = ~(bit_en_q ^ carry);
    // bit 95 repeats the sign, so an overflow shows as the borrow into bit 95 of the top section
    assign borrow96 = bit_br_q[94] | (bit_en_q[94] & (bit_br_q[93] | (bit_en_q[93]
        & (grp_br_q[20] | (grp_en_q[20] & sec_cin[10])))));
    // alike signs only; positives overflow without it, negatives with it
    assign coef_ovf = (ref_sign4_q == shf_sign4_q) && (ref_sign4_q ? borrow96 : !borrow96);
    // overflow paths are a wired one-place right shift
    assign upper_half = coef_ovf ? result[96:49] : result[95:48];
    assign lower_half = coef_ovf ? result[48:1] : result[47:0];

    // unsampled paths float to all ones at the destination
    always_comb begin
        if (samp_upper_q && samp_center_q) begin
            coef_sel = upper_half;
        end else if (samp_lower_q && samp_center_q) begin
            coef_sel = lower_half;
        end else begin
            coef_sel = {COEF_W{1'b1}};
        end
    end

    // result stage: the destination sees the word one edge after period four
    logic [47:0] coef_res_q;
    logic coef_ovf_q;
    logic exp_last_q;
    logic exp_pulse_q;
    logic done_q;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            coef_res_q <= RST_COEF;
            coef_ovf_q <= 1'b0;
            exp_last_q <= 1'b0;
            exp_pulse_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= p4_q;
            exp_pulse_q <= p4_q && samp_exp_q;
            if (p4_q) begin
                coef_res_q <= coef_sel;
                coef_ovf_q <= coef_ovf;
                exp_last_q <= samp_exp_q;
            end
        end
    end

    assign coef_result_out = coef_res_q;
    assign coef_overflow_out = coef_ovf_q;
    assign sample_exponent_out = exp_pulse_q;
    assign result_valid_out = done_q;

    // ==================================================================
    // bus slave: read channel
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] rd_word;
    logic rd_hit;

    assign arready_out = !rvalid_q;
    assign rvalid_out = rvalid_q;
    assign rdata_out = rdata_q;
    assign rresp_out = rresp_q;

    always_comb begin
        rd_hit = (araddr_in[1:0] == 2'h0) && (araddr_in <= ADDR_RES_HI);
        case (araddr_in)
            ADDR_OPJ_LO: rd_word = opj_lo_q;
            ADDR_OPJ_HI: rd_word = {16'h0000, opj_hi_q};
            ADDR_OPK_LO: rd_word = opk_lo_q;
            ADDR_OPK_HI: rd_word = {16'h0000, opk_hi_q};
            ADDR_SHIFT: rd_word = {23'h00_0000, shift_q};
            ADDR_CTRL: rd_word = {26'h000_0000, ctrl_q};
            ADDR_STATUS: begin
                rd_word = RST_WORD;
                rd_word[STAT_BUSY_BIT] = p2_q || p3_q || p4_q;
                rd_word[STAT_OVF_BIT] = coef_ovf_q;
                rd_word[STAT_EXP_BIT] = exp_last_q;
            end
            ADDR_RES_LO: rd_word = coef_res_q[31:0];
            ADDR_RES_HI: rd_word = {16'h0000, coef_res_q[47:32]};
            default: rd_word = RST_WORD;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rvalid_q <= 1'b0;
            rdata_q <= RST_WORD;
            rresp_q <= RESP_OKAY;
        end else if (arvalid_in && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_hit ? rd_word : RST_WORD;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && rready_in) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule : float_add_coefficient_path

// [verification/fac_checker_assertions.sv]
`timescale 1ns/1ps
module fac_checker import float_add_coef_pkg::*; (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] awaddr_in,
    input wire logic awvalid_in,
    input wire logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    input wire logic wready_out,
    input wire logic [1:0] bresp_out,
    input wire logic bvalid_out,
    input wire logic bready_in,
    input wire logic arvalid_in,
    input wire logic arready_out,
    input wire logic rvalid_out,
    input wire logic [47:0] coef_result_out,
    input wire logic coef_overflow_out,
    input wire logic sample_exponent_out,
    input wire logic result_valid_out
);
    // address and data taken at one edge; a go write is such a pair
    wire wr_take = awvalid_in && awready_out && wvalid_in && wready_out;
    wire go_take = wr_take && awaddr_in == ADDR_GO && wstrb_in[0] && wdata_in[0];
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    // ==========
    // bus handshakes
    a_write_answer: assert property (wr_take |=> bvalid_out)
        else $error("write not answered");
    a_bresp_hold: assert property (bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
        else $error("write answer dropped");
    a_ready_gap: assert property (bvalid_out |-> !awready_out && !wready_out)
        else $error("ready during answer");
    a_read_answer: assert property (arvalid_in && arready_out |=> rvalid_out && !arready_out)
        else $error("read not answered");
    // ==========
    // datapath: fixed four-period pipe, result moves only with its pulse
    a_go_latency: assert property (go_take |-> ##4 result_valid_out)
        else $error("result not four cycles after go");
    a_exp_pulse: assert property (sample_exponent_out |-> result_valid_out)
        else $error("exponent sample without result");
    a_result_held: assert property (!result_valid_out |-> $stable(coef_result_out) && $stable(coef_overflow_out))
        else $error("result moved without pulse");
    a_special_ones: assert property (result_valid_out && !sample_exponent_out |-> &coef_result_out)
        else $error("special case not all ones");
endmodule : fac_checker
bind float_add_coefficient_path fac_checker chk (.*);

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top import float_add_coef_pkg::*;;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] awaddr_in = '0, araddr_in = '0;
    logic [31:0] wdata_in = '0, rdata_out;
    logic [3:0] wstrb_in = '0;
    logic awvalid_in = 0, wvalid_in = 0, bready_in = 1, arvalid_in = 0, rready_in = 1;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
    logic coef_overflow_out, sample_exponent_out, result_valid_out;
    logic [1:0] bresp_out, rresp_out;
    logic [47:0] coef_result_out, opj, opk;
    logic [8:0] shf;
    logic [5:0] ctl;
    int mismatches = 0;
    int samples_checked = 0;
    // corners: positive overflow, negative pair, complemented zero shift, shift 128, special case
    logic [47:0] cv [5] = '{48'h7fff_ffff_ffff, 48'h8000_0000_0000, 48'h0123_4567_89ab, 48'h7654_3210_fedc, 48'h0001};
    logic [8:0] cs [5] = '{9'h000, 9'h000, 9'h107, 9'h080, 9'h003};
    logic [5:0] cc [5] = '{6'h3c, 6'h01, 6'h14, 6'h21, 6'h02};
    always #2.5 ref_clk_in = ~ref_clk_in;
    float_add_coefficient_path dut (.*);
    x_operand_model xm (.opj_out(opj), .opk_out(opk), .shift_out(shf), .ctrl_out(ctl));
    // ==========
    // expected {overflow, coefficient}
    function automatic logic [48:0] expect_res(logic [47:0] j, k, logic [8:0] s, logic [5:0] c);
        logic sd, rs, ss, ov;
        logic [47:0] rf, sh;
        logic [96:0] a, b, r;
        logic [97:0] t;
        int n;
        sd = s[8];
        rf = sd ? j : k;
        sh = sd ? k : j;
        rs = rf[47];
        ss = sh[47];
        n = s[7] ? 127 : int'(s[2:0] ^ {3{sd}}) + 8 * s[3] + 16 * s[4] + 32 * s[5] + 64 * s[6];
        a = {rs, rf, sd ? c[4] : c[5], {47{rs}}};
        b = $signed({ss, sh, sd ? c[3] : c[2], {47{ss}}}) >>> n;
        t = {1'b0, ~a} + {1'b0, ~b};
        r = ~(t[96:0] + 97'(t[97]));
        ov = rs == ss && r[96] != r[95];
        if (c[1])
            return {ov, 48'hffff_ffff_ffff};
        return {ov, c[0] ? (ov ? r[48:1] : r[47:0]) : (ov ? r[96:49] : r[95:48])};
    endfunction : expect_res
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // bus master: hold each channel until its ready, keep bready up until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr_in <= a;
        wdata_in <= d;
        wstrb_in <= 4'hf;
        awvalid_in <= 1'b1;
        wvalid_in <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            if (awready_out) awvalid_in <= 1'b0;
            if (wready_out) wvalid_in <= 1'b0;
        end while (bvalid_out !== 1'b1);
        chk(48'(bresp_out), 48'(er));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr_in <= a;
        arvalid_in <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            if (arready_out) arvalid_in <= 1'b0;
        end while (rvalid_out !== 1'b1);
        chk(48'(rdata_out), 48'(e));
        chk(48'(rresp_out), 48'(er));
    endtask : rd
    task automatic run_op;
        logic [48:0] e;
        int n;
        wr(ADDR_OPJ_LO, opj[31:0], RESP_OKAY);
        wr(ADDR_OPJ_HI, {16'h0000, opj[47:32]}, RESP_OKAY);
        wr(ADDR_OPK_LO, opk[31:0], RESP_OKAY);
        wr(ADDR_OPK_HI, {16'h0000, opk[47:32]}, RESP_OKAY);
        wr(ADDR_SHIFT, {23'h00_0000, shf}, RESP_OKAY);
        wr(ADDR_CTRL, {26'h000_0000, ctl}, RESP_OKAY);
        wr(ADDR_GO, 32'h0000_0001, RESP_OKAY);
        e = expect_res(opj, opk, shf, ctl);
        n = 0;
        while (result_valid_out !== 1'b1 && n++ < 10) @(posedge ref_clk_in);
        chk(48'(result_valid_out), 48'h1);
        chk(coef_result_out, e[47:0]);
        chk(48'(sample_exponent_out), 48'(!ctl[1]));
        if (!ctl[1]) chk(48'(coef_overflow_out), 48'(e[48]));
        rd(ADDR_RES_LO, e[31:0], RESP_OKAY);
    endtask : run_op
    task automatic conclude;
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    // ==========
    // main sequence: reset, bus corners, corner operands, then random operands
    initial begin
        void'($urandom(32'h653d_30b4));
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        rd(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
        rd(8'h40, 32'h0000_0000, RESP_SLVERR);
        rd(8'h02, 32'h0000_0000, RESP_SLVERR);
        wr(8'h40, 32'hffff_ffff, RESP_SLVERR);
        for (int i = 0; i < 40; i++) begin
            if (i < 5) xm.load(cv[i], cv[i], cs[i], cc[i]);
            else xm.draw();
            run_op();
        end
        conclude();
    end
    // watchdog: whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        mismatches++;
        conclude();
    end
endmodule : tb_top

// [verification/x_operand_model.sv]
`timescale 1ns/1ps
module x_operand_model (
    output logic [47:0] opj_out,
    output logic [47:0] opk_out,
    output logic [8:0] shift_out,
    output logic [5:0] ctrl_out
);
    // ==========
    // operands hold until the next load, so period two sees what issue wrote
    task automatic load(input logic [47:0] j, k, input logic [8:0] s, input logic [5:0] c);
        opj_out = j;
        opk_out = k;
        shift_out = s;
        ctrl_out = c;
    endtask : load
    // special case one draw in sixteen, so most draws reach the adder
    task automatic draw;
        load(48'({$urandom, $urandom}), 48'({$urandom, $urandom}), 9'($urandom),
            6'($urandom) & {4'hf, $urandom_range(7) == 0, 1'b1});
    endtask : draw
endmodule : x_operand_model
